// ### hw/ctw_pkg.sv
// Package with the shared constants and types of the CAN mode/wake block
package ctw_pkg;
   // Operating modes; Gray steps along the usual path
   typedef enum logic [1:0] {
      CTW_NORMAL  = 2'h0,
      CTW_RXONLY  = 2'h1,
      CTW_STANDBY = 2'h3,
      CTW_SLEEP   = 2'h2
   } ctw_mode_t;
   // Remote wake pattern states; Gray along the pattern
   typedef enum logic [1:0] {
      CTW_P_IDLE = 2'h0,
      CTW_P_DOM1 = 2'h1,
      CTW_P_REC  = 2'h3,
      CTW_P_DOM2 = 2'h2
   } ctw_pat_t;
   // Sticky status flags, one bit each
   typedef struct packed {
      logic battery_undervolt_flag;
      logic battery_power_ok_flag;
      logic converter_undervolt_flag;
      logic converter_power_ok_flag;
      logic reg2_undervolt_flag;
      logic reg2_power_ok_flag;
      logic reg3_undervolt_flag;
      logic reg3_power_ok_flag;
      logic bus_wake_flag;
      logic local_wake_flag;
      logic overtemp_warning_flag;
      logic overtemp_recover_flag;
      logic high_line_overcurrent_flag;
      logic high_line_undercurrent_flag;
      logic low_line_overcurrent_flag;
      logic low_line_undercurrent_flag;
   } ctw_flags_t;
   // Supply comparator levels: uv = below undervolt, pok = above power-ok
   typedef struct packed {
      logic bt_uv;
      logic bt_pok;
      logic cv_uv;
      logic cv_pok;
      logic r2_uv;
      logic r2_pok;
      logic r3_uv;
      logic r3_pok;
   } ctw_supply_t;
   // Register byte offsets
   localparam logic [11:0] CTW_CTRL_OFS = 12'h000;
   localparam logic [11:0] CTW_STAT_OFS = 12'h004;
   localparam logic [11:0] CTW_FLAG_OFS = 12'h008;
   // Reset values and field layout
   localparam ctw_mode_t   CTW_MODE_RST  = CTW_STANDBY;
   localparam logic [5:0]  CTW_FLT_RST   = 6'h02;
   localparam logic [15:0] CTW_BUSF_MASK = 16'h000f;
   localparam int          CTW_FLAG_W    = 16;
   localparam int          CTW_NFILT     = 6;
   localparam int          CTW_F_WAKE    = 0;
   localparam int          CTW_F_BUS     = 1;
   localparam int          CTW_F_LINE    = 2;
endpackage

// ### hw/ctw_top.sv
// CAN transceiver mode control, wake detection and status flags
//
// What this block does
// - Normal: driver and normal receiver on
// - Receive-only: as normal, driver off
// - Standby/sleep: low-power receiver, wake detect, undriven
// - Low power: wake levels mirror filtered detectors
// - Wake low past filter: level low, pull-down
// - Wake high past filter: level high, pull-up
// - Local wake only on filtered rising edge
// - Remote level follows bus past filter time in standby/sleep
// - Remote wake: two dominant pulses, long recessive gap
// - Pattern detection runs only in standby/sleep
// - Any set flag raises the interrupt
// - Battery undervolt: flag, standby, transceiver off
// - Battery power-ok flag on recovery
// - Converter undervolt: flag, standby, transceiver off
// - Converter power-ok flag on recovery
// - Regulator 2/3 undervolt flags set and clear
// - Regulator 2/3 power-ok flags on recovery
// - Bus wake flag on remote pattern
// - Local wake flag on valid rising wake edge in standby/sleep
// - Over-temperature warning and recover flags
// - Bus failure flags clear on read, refire
// - Line-current faults only after filter time
// - Interrupt low while any flag set
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module ctw_top #(
   parameter int CNT_W     = 16, // Width of filter counters
   parameter int LW_FILT   = 40, // Local wake filter, cycles
   parameter int BUS_FILT  = 20, // Bus wake filter, cycles
   parameter int REC_WAKE  = 40, // Least recessive gap, cycles
   parameter int LINE_FILT = 8   // Line-current filter, cycles
) (
   input  wire logic               clock,
   input  wire logic               nrst,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Protocol controller side
   input  wire logic               txd,
   output logic                    rxd,
   // Bus side
   input  wire logic               bus_dominant,
   output logic                    tx_dom,
   output logic                    tx_en,
   output logic                    norm_rx_en,
   output logic                    lp_rx_en,
   // Wake pin
   input  wire logic               wake_above,
   output logic                    wake_pullup,
   output logic                    wake_local,
   output logic                    wake_remote,
   // Analogue monitors
   input  wire ctw_pkg::ctw_supply_t supply,
   input  wire logic               temp_warn,
   input  wire logic               temp_below_recv,
   input  wire logic [3:0]         line_raw,
   // Filtered line-current comparators and the interrupt
   output logic                    high_line_overcurrent_cmp,
   output logic                    high_line_undercurrent_cmp,
   output logic                    low_line_overcurrent_cmp,
   output logic                    low_line_undercurrent_cmp,
   output logic                    irq_n_out
);
   import ctw_pkg::*;

   // Refuse counts the counters cannot hold
   initial begin
      if (LW_FILT < 1 || LW_FILT >= (1 << CNT_W) ||
          BUS_FILT < 1 || BUS_FILT >= (1 << CNT_W) ||
          REC_WAKE < 1 || REC_WAKE >= (1 << CNT_W) ||
          LINE_FILT < 1 || LINE_FILT >= (1 << CNT_W))
         $error("ctw_top: filter count out of range");
   end

   // True for the two low-power modes
   function automatic logic is_lp(input ctw_mode_t m);
      is_lp = (m == CTW_STANDBY) || (m == CTW_SLEEP);
   endfunction

   // Filter length per filter index
   function automatic logic [CNT_W-1:0] flen_f(input int i);
      int n;
      n = LINE_FILT;
      if (i == CTW_F_WAKE)
         n = LW_FILT;
      else if (i == CTW_F_BUS)
         n = BUS_FILT;
      flen_f = CNT_W'(n);
   endfunction

   ctw_mode_t        mode_q;       // Current operating mode
   ctw_pat_t         pat_q;        // Remote wake pattern state
   logic [CNT_W-1:0] rec_cnt_q;    // Recessive gap length
   ctw_flags_t       flags_q;      // Sticky flags
   ctw_flags_t       flags_d;      // Next flags
   ctw_flags_t       set_v;        // Hardware set terms
   ctw_flags_t       clr_v;        // Clear terms
   ctw_supply_t      sup_q;        // Previous supply levels
   logic             warn_q;       // Previous warning level
   logic             recv_q;       // Previous recovery level
   logic             wl_q;         // Previous local wake level
   logic             lp;           // Low-power mode now
   logic             xcv_off;      // Transceiver forced off
   logic [CTW_NFILT-1:0] filt_in;  // Filter inputs
   logic [CTW_NFILT-1:0] filt_en;  // Filter enables
   logic [CTW_NFILT-1:0] flt;      // Filtered levels
   logic [31:0]      prdata_q;     // Read data register
   logic             rd_acc;       // Read access phase
   logic             wr_acc;       // Write access phase
   logic             rd_setup;     // Read setup phase
   logic             map_ok;       // Address decodes
   logic [31:0]      rd_mux;       // Read data source
   logic             tx_en_q;      // Driver enable register
   logic             tx_dom_q;     // Dominant drive register
   logic             rxd_q;        // Receive output register

   assign lp = is_lp(mode_q);
   // Battery or converter undervolt switches the transceiver off
   assign xcv_off = flags_q.battery_undervolt_flag ||
                    flags_q.converter_undervolt_flag;

   // Filter inputs: wake pin, bus recessive, four line comparators
   assign filt_in = {line_raw, ~bus_dominant, wake_above};
   assign filt_en = {4'hf, lp, lp};

   // Glitch filters: level changes once input differs past length
   genvar gi;
   for (gi = 0; gi < CTW_NFILT; gi++) begin : g_filt
      logic [CNT_W-1:0] cnt_q; // Cycles input has differed
      logic             lvl_q; // Filtered level
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            cnt_q <= '0;
            lvl_q <= CTW_FLT_RST[gi];
         end else if (!filt_en[gi] || filt_in[gi] == lvl_q) begin
            cnt_q <= '0;
         end else if (cnt_q == flen_f(gi)) begin
            // Differed longer than filter time
            lvl_q <= filt_in[gi];
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
      assign flt[gi] = lvl_q;
   end

   // Wake levels and bias follow the filtered detectors
   assign wake_local  = flt[CTW_F_WAKE];
   assign wake_pullup = flt[CTW_F_WAKE];
   assign wake_remote = flt[CTW_F_BUS];
   assign high_line_overcurrent_cmp  = flt[CTW_F_LINE+3];
   assign high_line_undercurrent_cmp = flt[CTW_F_LINE+2];
   assign low_line_overcurrent_cmp   = flt[CTW_F_LINE+1];
   assign low_line_undercurrent_cmp  = flt[CTW_F_LINE];

   // Remote wake pattern: dominant, long recessive, dominant
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pat_q     <= CTW_P_IDLE;
         rec_cnt_q <= '0;
      end else if (!lp) begin
         // Detection stopped outside low power
         pat_q     <= CTW_P_IDLE;
         rec_cnt_q <= '0;
      end else begin
         case (pat_q)
            CTW_P_IDLE: begin
               // First filtered dominant pulse
               if (!wake_remote)
                  pat_q <= CTW_P_DOM1;
            end
            CTW_P_DOM1: begin
               // Recessive gap begins
               if (wake_remote) begin
                  pat_q     <= CTW_P_REC;
                  rec_cnt_q <= '0;
               end
            end
            CTW_P_REC: begin
               if (!wake_remote) begin
                  // Gap long enough gives second pulse
                  if (rec_cnt_q >= CNT_W'(REC_WAKE))
                     pat_q <= CTW_P_DOM2;
                  else
                     pat_q <= CTW_P_DOM1;
               end else if (rec_cnt_q < CNT_W'(REC_WAKE)) begin
                  rec_cnt_q <= rec_cnt_q + 1'b1;
               end
            end
            CTW_P_DOM2: begin
               // Pattern found; wait for bus to free again
               if (wake_remote)
                  pat_q <= CTW_P_IDLE;
            end
            default: begin
               pat_q <= CTW_P_IDLE;
            end
         endcase
      end
   end

   // Previous levels for edge detection
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sup_q  <= '0;
         warn_q <= 1'b0;
         recv_q <= 1'b0;
         wl_q   <= 1'b0;
      end else begin
         sup_q  <= supply;
         warn_q <= temp_warn;
         recv_q <= temp_below_recv;
         wl_q   <= wake_local;
      end
   end

   // APB decode
   assign rd_setup = psel && !penable && !pwrite;
   assign rd_acc   = psel && penable && !pwrite;
   assign wr_acc   = psel && penable && pwrite;
   assign map_ok   = (paddr == CTW_CTRL_OFS) ||
                     (paddr == CTW_STAT_OFS) ||
                     (paddr == CTW_FLAG_OFS);

   // Hardware set terms for the flags
   always_comb begin
      set_v = '0;
      set_v.battery_undervolt_flag   = supply.bt_uv;
      set_v.battery_power_ok_flag    = supply.bt_pok &&
                                       !sup_q.bt_pok;
      set_v.converter_undervolt_flag = supply.cv_uv;
      set_v.converter_power_ok_flag  = supply.cv_pok &&
                                       !sup_q.cv_pok;
      set_v.reg2_undervolt_flag      = supply.r2_uv;
      set_v.reg2_power_ok_flag       = supply.r2_pok &&
                                       !sup_q.r2_pok;
      set_v.reg3_undervolt_flag      = supply.r3_uv;
      set_v.reg3_power_ok_flag       = supply.r3_pok &&
                                       !sup_q.r3_pok;
      set_v.bus_wake_flag            = lp && !wake_remote &&
                                       pat_q == CTW_P_REC &&
                                       rec_cnt_q >=
                                       CNT_W'(REC_WAKE);
      set_v.local_wake_flag          = lp && wake_local &&
                                       !wl_q;
      set_v.overtemp_warning_flag    = temp_warn && !warn_q;
      set_v.overtemp_recover_flag    = temp_below_recv &&
                                       !recv_q;
      // Persisting line faults keep setting their flags
      set_v.high_line_overcurrent_flag  =
         high_line_overcurrent_cmp;
      set_v.high_line_undercurrent_flag =
         high_line_undercurrent_cmp;
      set_v.low_line_overcurrent_flag   =
         low_line_overcurrent_cmp;
      set_v.low_line_undercurrent_flag  =
         low_line_undercurrent_cmp;
   end

   // Clear terms: write one to clear, read clears bus failures
   always_comb begin
      clr_v = '0;
      if (wr_acc && paddr == CTW_FLAG_OFS)
         clr_v = ctw_flags_t'(pwdata[CTW_FLAG_W-1:0] & ~CTW_BUSF_MASK);
      if (rd_acc && paddr == CTW_FLAG_OFS)
         clr_v = ctw_flags_t'(CTW_BUSF_MASK);
      // Undervolt flags clear once above power-ok
      clr_v.battery_undervolt_flag   = supply.bt_pok;
      clr_v.converter_undervolt_flag = supply.cv_pok;
      clr_v.reg2_undervolt_flag      = supply.r2_pok;
      clr_v.reg3_undervolt_flag      = supply.r3_pok;
      // Set wins over clear
      flags_d = (flags_q & ~clr_v) | set_v;
   end

   // Sticky flag register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         flags_q <= '0;
      else
         flags_q <= flags_d;
   end

   // Interrupt low while any flag is set
   assign irq_n_out = !(|flags_q);

   // Operating mode: host writes, battery or converter undervolt forces standby
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_q <= CTW_MODE_RST;
      end else if (supply.bt_uv || supply.cv_uv) begin
         mode_q <= CTW_STANDBY;
      end else if (wr_acc && paddr == CTW_CTRL_OFS) begin
         mode_q <= ctw_mode_t'(pwdata[1:0]);
      end
   end

   // Transceiver path registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tx_en_q  <= 1'b0;
         tx_dom_q <= 1'b0;
         rxd_q    <= 1'b1;
      end else begin
         // Driver only in normal mode and with no battery or converter undervolt flag set
         tx_en_q  <= mode_q == CTW_NORMAL && !xcv_off;
         tx_dom_q <= mode_q == CTW_NORMAL && !xcv_off &&
                     !txd;
         // Receive output follows bus, or remote level in low power
         rxd_q    <= lp ? wake_remote : !bus_dominant;
      end
   end

   assign tx_en      = tx_en_q;
   assign tx_dom     = tx_dom_q;
   assign rxd        = rxd_q;
   assign norm_rx_en = !lp && !xcv_off;
   assign lp_rx_en   = lp;

   // Read multiplexer
   always_comb begin
      rd_mux = '0;
      case (paddr)
         CTW_CTRL_OFS: rd_mux[1:0] = mode_q;
         CTW_STAT_OFS: begin
            rd_mux[1:0] = mode_q;
            rd_mux[3:2] = pat_q;
            rd_mux[4]   = wake_local;
            rd_mux[5]   = wake_remote;
            rd_mux[6]   = wake_pullup;
            rd_mux[7]   = tx_en_q;
            rd_mux[11:8] = flt[CTW_NFILT-1:CTW_F_LINE];
         end
         CTW_FLAG_OFS: rd_mux[CTW_FLAG_W-1:0] = flags_q;
         default: rd_mux = '0;
      endcase
   end

   // Read data captured in setup, stands through access
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         prdata_q <= '0;
      else if (rd_setup)
         prdata_q <= rd_mux;
   end

   assign prdata  = prdata_q;
   assign pready  = psel && penable;
   assign pslverr = psel && penable && !map_ok;

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_gap;
      pat_q == CTW_P_REC && rec_cnt_q >= CNT_W'(REC_WAKE);
   endsequence

   drv_off_a: assert property (mode_q != CTW_NORMAL |=> !tx_en)
      else $error("driver on outside normal mode");
   drv_dom_a: assert property (
      mode_q == CTW_NORMAL && !xcv_off && !txd && !$past(txd)
      |=> tx_dom && tx_en)
      else $error("low txd did not drive dominant");
   lp_rx_a: assert property (lp |-> lp_rx_en && !norm_rx_en)
      else $error("receiver selection wrong in low power");
   irq_lvl_a: assert property ((|set_v) |=> !irq_n_out)
      else $error("interrupt not low after a flag was set");
   lwake_flag_a: assert property (
      lp && $rose(wake_local) |=> flags_q.local_wake_flag)
      else $error("local wake flag missed");
   uv_stby_a: assert property (
      supply.bt_uv |=> mode_q == CTW_STANDBY &&
      flags_q.battery_undervolt_flag ##1 !tx_en)
      else $error("battery undervolt not handled");
   busf_clr_a: assert property (
      rd_acc && paddr == CTW_FLAG_OFS && !high_line_overcurrent_cmp
      |=> !flags_q.high_line_overcurrent_flag)
      else $error("bus failure flag not cleared by read");
   bwake_pat_a: assert property (
      s_gap ##1 (lp && pat_q == CTW_P_DOM2)
      |-> flags_q.bus_wake_flag)
      else $error("remote wake pattern not flagged");
   pat_idle_a: assert property (!lp |=> pat_q == CTW_P_IDLE)
      else $error("pattern detection active outside low power");
   line_filt_a: assert property (
      $rose(high_line_overcurrent_cmp) |-> $past(line_raw[3]) &&
      $past(line_raw[3], 2))
      else $error("line fault passed without filtering");
endmodule

// ### testbench/ctw_bus_model.sv
// Behavioural model of the physical bus and the other nodes on it
`timescale 1ns/100ps
module ctw_bus_model (
   input  wire logic tx_en,        // Driver enable of the block
   input  wire logic tx_dom,       // Block pulls the bus dominant
   input  wire logic remote_dom,   // Another node sends dominant
   output logic      bus_dominant  // Differential level seen by receivers
);
   // Wired dominant; termination pulls an undriven bus recessive
   assign bus_dominant = (tx_en & tx_dom) | remote_dom;
endmodule

// ### testbench/ctw_top_tb.sv
// Self-checking testbench for the CAN mode, wake and flag block
`timescale 1ns/100ps
module ctw_top_tb;
   import ctw_pkg::*;
   logic        clock, nrst, psel, penable, pwrite, pslverr, pready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic        txd, rxd, bus_dominant, tx_dom, tx_en, norm_rx_en;
   logic        lp_rx_en, wake_above, wake_pullup, wake_local, wake_remote;
   logic        temp_warn, temp_below_recv, remote_dom, serr, irq_n_out;
   logic [3:0]  line_raw;
   wire  [3:0]  cmps;        // Filtered line comparators, one port a bit
   ctw_supply_t supply;
   int          errors, comparisons, cycles;

   ctw_top #(.LW_FILT(3), .BUS_FILT(3), .REC_WAKE(8), .LINE_FILT(3))
   ctw_top_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd),
      .bus_dominant(bus_dominant), .tx_dom(tx_dom), .tx_en(tx_en),
      .norm_rx_en(norm_rx_en), .lp_rx_en(lp_rx_en),
      .wake_above(wake_above), .wake_pullup(wake_pullup),
      .wake_local(wake_local), .wake_remote(wake_remote),
      .supply(supply), .temp_warn(temp_warn),
      .temp_below_recv(temp_below_recv), .line_raw(line_raw),
      .high_line_overcurrent_cmp(cmps[3]),
      .high_line_undercurrent_cmp(cmps[2]),
      .low_line_overcurrent_cmp(cmps[1]),
      .low_line_undercurrent_cmp(cmps[0]), .irq_n_out(irq_n_out));
   ctw_bus_model ctw_bus_model_i (.tx_en(tx_en), .tx_dom(tx_dom),
      .remote_dom(remote_dom), .bus_dominant(bus_dominant));

   // Clock at 40 MHz
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         end_of_test();
      end
   end

   // Counts and verdict, then stop
   task end_of_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compare one value with its expectation
   task chk(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Let the edge's updates land before looking
   task settle();
      @(negedge clock);
   endtask

   // Read the flags, compare, then clear the sticky ones
   task fl(input logic [15:0] exp);
      apb(1'b0, CTW_FLAG_OFS, 32'h0);
      chk("flags", {16'h0, rdata[15:0]}, {16'h0, exp});
      apb(1'b1, CTW_FLAG_OFS, 32'hfff0);
   endtask

   task mode(input ctw_mode_t m);
      apb(1'b1, CTW_CTRL_OFS, {30'h0, m});
   endtask

   // One dominant pulse from another node, then a recessive gap
   task pulse(input int gap);
      remote_dom <= 1'b1;
      cyc(8);
      remote_dom <= 1'b0;
      cyc(gap);
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, wake_above, remote_dom} = '0;
      {supply, temp_warn, temp_below_recv, line_raw} = '0;
      txd = 1'b1;
      nrst = 1'b0;
      errors = 0;
      comparisons = 0;
      cycles = 0;
      cyc(5);
      nrst <= 1'b1;
      settle();
      chk("lp_rx_en", lp_rx_en, 1'b1);
      chk("norm_rx_en", norm_rx_en, 1'b0);
      chk("irq idle", irq_n_out, 1'b1);
      // Wake pattern in normal mode is ignored
      mode(CTW_NORMAL);
      pulse(20);
      pulse(20);
      fl(16'h0);
      // Normal mode drives and receives
      txd <= 1'b0;
      cyc(4);
      settle();
      chk("tx_en", tx_en, 1'b1);
      chk("tx_dom", tx_dom, 1'b1);
      chk("rxd dom", rxd, 1'b0);
      chk("rx enables", {norm_rx_en, lp_rx_en}, 2'b10);
      cyc(1);
      txd <= 1'b1;
      cyc(4);
      settle();
      chk("rxd rec", rxd, 1'b1);
      // Receive-only keeps the driver off
      mode(CTW_RXONLY);
      txd <= 1'b0;
      cyc(4);
      settle();
      chk("rxonly tx_en", tx_en, 1'b0);
      chk("rxonly rxd", rxd, 1'b1);
      cyc(1);
      remote_dom <= 1'b1;
      cyc(4);
      settle();
      chk("rxonly rx", rxd, 1'b0);
      cyc(1);
      remote_dom <= 1'b0;
      txd <= 1'b1;
      // Sleep: local wake with a filtered glitch
      mode(CTW_SLEEP);
      cyc(2);
      settle();
      chk("sleep en", {tx_en, norm_rx_en, lp_rx_en}, 3'b001);
      cyc(1);
      wake_above <= 1'b1;
      cyc(2);
      wake_above <= 1'b0;
      cyc(8);
      settle();
      chk("glitch", wake_local, 1'b0);
      cyc(1);
      wake_above <= 1'b1;
      cyc(8);
      settle();
      chk("wake up", {wake_local, wake_pullup}, 2'b11);
      chk("irq set", irq_n_out, 1'b0);
      fl(16'h0040);
      settle();
      chk("irq clr", irq_n_out, 1'b1);
      cyc(1);
      wake_above <= 1'b0;
      cyc(8);
      settle();
      chk("wake dn", {wake_local, wake_pullup}, 2'b00);
      fl(16'h0);
      // Remote wake: short gap restarts, long gap completes
      pulse(6);
      pulse(6);
      fl(16'h0);
      pulse(20);
      settle();
      chk("remote lvl", wake_remote, 1'b1);
      fl(16'h0080);
      // Supplies: battery, converter, regulators 2 and 3
      for (int i = 0; i < 4; i++) begin
         mode(CTW_NORMAL);
         supply[7-2*i] <= 1'b1;
         cyc(4);
         apb(1'b1, CTW_CTRL_OFS, 32'h0);
         apb(1'b0, CTW_STAT_OFS, 32'h0);
         chk("uv mode", rdata[1:0], (i < 2) ? 2'h3 : 2'h0);
         chk("uv tx_en", tx_en, (i < 2) ? 1'b0 : 1'b1);
         fl(16'h8000 >> (2 * i));
         supply[7-2*i] <= 1'b0;
         supply[6-2*i] <= 1'b1;
         cyc(4);
         fl(16'h4000 >> (2 * i));
         supply[6-2*i] <= 1'b0;
      end
      // Temperature warning and recovery
      mode(CTW_NORMAL);
      temp_warn <= 1'b1;
      cyc(3);
      fl(16'h0020);
      temp_warn <= 1'b0;
      temp_below_recv <= 1'b1;
      cyc(3);
      fl(16'h0010);
      // Line-current faults: filter, clear on read, refire
      for (int k = 0; k < 4; k++) begin
         line_raw[k] <= 1'b1;
         cyc(2);
         line_raw[k] <= 1'b0;
         cyc(6);
         fl(16'h0);
         line_raw[k] <= 1'b1;
         cyc(8);
         settle();
         chk("line cmp", cmps, 4'h1 << k);
         fl(16'h1 << k);
         fl(16'h1 << k);
         line_raw[k] <= 1'b0;
         cyc(8);
         fl(16'h1 << k);
         fl(16'h0);
         apb(1'b0, CTW_STAT_OFS, 32'h0);
         chk("line mode", rdata[1:0], 2'h0);
      end
      // Unmapped address
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped err", serr, 1'b1);
      chk("unmapped data", rdata, 32'h0);
      end_of_test();
   end
endmodule
